// >>> bench/rxsp_port_properties.sv
`timescale 1ns/1ps
// port checker: read side outputs against the link pins
module rxsp_port_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration and link pins
  input wire logic cfg_packet_mode,
  input wire logic cfg_level3,
  input wire logic cfg_odd_parity,
  input wire logic rx_fifo_read_clock,
  input wire logic rx_read_enable_n,
  input wire logic [31:0] rx_data_bus,
  input wire logic rx_data_parity,
  input wire logic rx_start_of_cell,
  input wire logic rx_end_of_packet,
  input wire logic rx_packet_error,
  // fifo side
  input wire logic fifo_pop,
  input wire logic [31:0] fifo_data,
  input wire logic fifo_first,
  input wire logic fifo_last
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since a read clock rise with enable low; sync lag is short,
  // so a data bus move long after such a rise is a hold failure
  logic rc_q;
  logic [3:0] since_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_q <= 1'b0;
      since_q <= 4'hf;
    end else begin
      rc_q <= rx_fifo_read_clock;
      if (rx_fifo_read_clock && !rc_q && !rx_read_enable_n) since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
  end
  pop_pulse_a: assert property (fifo_pop |=> !fifo_pop)
    else $error("fifo pop longer than one cycle");
  out_hold_a: assert property ($changed(rx_data_bus) |-> since_q < 4'h8)
    else $error("data bus moved without a read");
  l3_data_a: assert property (fifo_pop && cfg_level3 |=>
    rx_data_bus == $past(fifo_data)) else $error("level 3 data wrong");
  l2_data_a: assert property (fifo_pop && !cfg_level3 |=>
    rx_data_bus == {16'h0, $past(fifo_data[15:0])})
    else $error("level 2 data wrong");
  parity_sense_a: assert property (fifo_pop |=>
    rx_data_parity == (^rx_data_bus ^ cfg_odd_parity))
    else $error("parity wrong");
  error_needs_eop_a: assert property (rx_packet_error |-> rx_end_of_packet)
    else $error("error without end of packet");
  cell_start_a: assert property (fifo_pop && !cfg_packet_mode |=>
    rx_start_of_cell == $past(fifo_first)) else $error("start of cell");
  packet_end_a: assert property (fifo_pop && cfg_packet_mode |=>
    rx_end_of_packet == $past(fifo_last)) else $error("end of packet");
endmodule : rxsp_port_props
bind rxsp_port rxsp_port_props u_rxsp_port_props (.*);

// >>> bench/rxsp_port_tb.sv
`timescale 1ns/1ps
module rxsp_port_tb;
  import rxsp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, want_rd = 1'b0;
  logic cfg_packet_mode = 1'b0, cfg_level3 = 1'b0, cfg_odd_parity = 1'b0;
  logic rx_fifo_read_clock, rx_read_enable_n, rx_data_parity, fifo_pop;
  logic rx_start_of_cell, rx_start_of_packet, rx_end_of_packet;
  logic rx_packet_error, rx_data_valid, rx_transfer_start;
  logic [4:0] rx_channel_address, fifo_channel, want_addr = 5'h00;
  logic [31:0] rx_data_bus, fifo_data = 32'h0;
  logic [1:0] rx_word_modulo, fifo_mod = 2'h0;
  logic fifo_avail = 1'b1, fifo_first = 1'b0, fifo_last = 1'b0;
  logic fifo_bad = 1'b0, fifo_chan_report = 1'b0;
  int idx = 0, failures = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  rxsp_port u_rxsp_port (.*);
  rxsp_reader u_rxsp_reader (.want_rd(want_rd), .want_addr(want_addr),
    .rx_fifo_read_clock(rx_fifo_read_clock),
    .rx_read_enable_n(rx_read_enable_n),
    .rx_channel_address(rx_channel_address));
  function automatic logic [31:0] word(input int i);
    return {8'(i), 8'(~i), 8'h3c ^ 8'(i), 8'(i * 7)};
  endfunction : word
  // fifo head word; short packets where first and last coincide
  always @(negedge clk) begin
    fifo_data <= word(idx);
    fifo_first <= (idx % 3 == 0);
    fifo_last <= (idx % 3 != 1);
    fifo_mod <= 2'(idx);
    fifo_bad <= idx[2];
  end
  always @(posedge clk) if (fifo_pop === 1'b1) idx <= idx + 1;
  task automatic chk(input string nm, input logic [63:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // read five words in one mode, move the address after the first word, then idle
  task automatic run_mode(input logic p, l, o);
    int i0, k;
    logic f, e;
    logic [4:0] a0;
    logic [31:0] d;
    logic [63:0] snap;
    cfg_packet_mode = p;
    cfg_level3 = l;
    cfg_odd_parity = o;
    a0 = {3'h1, p, l};
    want_addr = a0;
    want_rd = 1'b1;
    repeat (5) begin
      k = 0;
      while (fifo_pop !== 1'b1 && k < 40) begin
        @(negedge clk);
        k++;
      end
      i0 = idx;
      @(negedge clk);
      d = word(i0);
      if (!l) d[31:16] = 16'h0;
      f = (i0 % 3 == 0);
      e = (i0 % 3 != 1) & p;
      chk("data", d, rx_data_bus);
      chk("parity", ^d ^ o, rx_data_parity);
      chk("channel", a0, fifo_channel);
      chk("flags", {~p & f, p & f, e, e & i0[2], p,
        e ? {l & i0[1], i0[0]} : 2'h0}, {rx_start_of_cell,
        rx_start_of_packet, rx_end_of_packet, rx_packet_error,
        rx_data_valid, rx_word_modulo});
      want_addr = ~a0;
    end
    want_rd = 1'b0;
    repeat (16) @(negedge clk);
    snap = {rx_data_bus, rx_data_parity, rx_start_of_cell, rx_data_valid};
    repeat (24) @(negedge clk);
    chk("hold", snap, {rx_data_bus, rx_data_parity,
      rx_start_of_cell, rx_data_valid});
  endtask : run_mode
  // in-band channel report in level 3 packet mode
  task automatic chan_report();
    int k;
    cfg_packet_mode = 1'b1;
    cfg_level3 = 1'b1;
    fifo_chan_report = 1'b1;
    want_addr = 5'h15;
    want_rd = 1'b1;
    k = 0;
    while (rx_transfer_start !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("report", {27'h0, 5'h15, 2'b01}, {rx_data_bus, rx_data_valid,
      rx_transfer_start});
    want_rd = 1'b0;
    fifo_chan_report = 1'b0;
    repeat (24) @(negedge clk);
  endtask : chan_report
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    run_mode(1'b0, 1'b1, 1'b0);
    run_mode(1'b0, 1'b0, 1'b1);
    run_mode(1'b1, 1'b1, 1'b1);
    run_mode(1'b1, 1'b0, 1'b0);
    chan_report();
    test_done();
  end
endmodule : rxsp_port_tb

// >>> bench/rxsp_reader.sv
`timescale 1ns/1ps
// link-layer reader: read clock, enable and address pins
module rxsp_reader (
  // requests from the bench
  input wire logic want_rd,
  input wire logic [4:0] want_addr,
  // link pins
  output logic rx_fifo_read_clock,
  output logic rx_read_enable_n,
  output logic [4:0] rx_channel_address
);
  // never gapped, 200 ns, phase offset from clk
  initial begin
    rx_fifo_read_clock = 1'b0;
    rx_read_enable_n = 1'b1;
    rx_channel_address = 5'h00;
    #37;
    forever #100 rx_fifo_read_clock = ~rx_fifo_read_clock;
  end
  // change just after a rise; address stands with the enable fall
  always @(posedge rx_fifo_read_clock) begin
    #5;
    rx_read_enable_n = ~want_rd;
    rx_channel_address = want_addr;
  end
endmodule : rxsp_reader

// >>> hw/rxsp_pkg.sv
package rxsp_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int CHAN_W = 8;
  localparam int ADDR_W = 5;
  localparam int MOD_W = 2;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CHAN_LSB = 0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [1:0] MOD_RST = 2'h0;
  localparam logic [4:0] ADDR_RST = 5'h00;
  // ----------------------------------------------------------------
  // read clock limits, for reference by the bench
  // ----------------------------------------------------------------
  localparam int L3_CLK_MIN_MHZ = 60;
  localparam int L3_CLK_MAX_MHZ = 104;
  localparam int L2_CLK_MIN_MHZ = 30;
  localparam int L2_CLK_MAX_MHZ = 52;
  // ----------------------------------------------------------------
  // sampler depth
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
endpackage : rxsp_pkg

// >>> hw/rxsp_port.sv
`timescale 1ns/1ps
module rxsp_port
  import rxsp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // configuration
  input wire logic cfg_packet_mode,
  input wire logic cfg_level3,
  input wire logic cfg_odd_parity,
  // link pins
  input wire logic rx_fifo_read_clock,
  input wire logic rx_read_enable_n,
  input wire logic [rxsp_pkg::ADDR_W-1:0] rx_channel_address,
  output logic [rxsp_pkg::DATA_W-1:0] rx_data_bus,
  output logic rx_data_parity,
  output logic rx_start_of_cell,
  output logic rx_start_of_packet,
  output logic rx_end_of_packet,
  output logic [rxsp_pkg::MOD_W-1:0] rx_word_modulo,
  output logic rx_packet_error,
  output logic rx_data_valid,
  output logic rx_transfer_start,
  // fifo side: word for the selected channel
  output logic [rxsp_pkg::ADDR_W-1:0] fifo_channel,
  output logic fifo_pop,
  input wire logic fifo_avail,
  input wire logic [rxsp_pkg::DATA_W-1:0] fifo_data,
  input wire logic fifo_first,
  input wire logic fifo_last,
  input wire logic [rxsp_pkg::MOD_W-1:0] fifo_mod,
  input wire logic fifo_bad,
  input wire logic fifo_chan_report
);
  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  localparam int PIN_W = 2 + ADDR_W;
  logic [PIN_W-1:0] pin_sync;
  logic rclk_s;
  logic rx_read_enable_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic rclk_prev_q;
  logic rx_read_enable_n_prev_q;
  logic [ADDR_W-1:0] chan_q;
  logic [DATA_W-1:0] data_q;
  logic par_q;
  logic soc_q;
  logic sop_q;
  logic eop_q;
  logic [MOD_W-1:0] mod_q;
  logic err_q;
  logic val_q;
  logic sx_q;

  rxsp_sync #(.W(PIN_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({rx_fifo_read_clock, rx_read_enable_n, rx_channel_address}),
    .sync_out(pin_sync)
  );

  assign rclk_s = pin_sync[PIN_W-1];
  assign rx_read_enable_n_s = pin_sync[PIN_W-2];
  assign addr_s = pin_sync[ADDR_W-1:0];

  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  // the read clock is assumed free-running in every mode
  wire rclk_rise = rclk_s & ~rclk_prev_q;
  // enable sampled low on a read-clock rise moves the bus
  wire read_taken = rclk_rise & ~rx_read_enable_n_s;
  // high-to-low seen across two read-clock samples
  wire sel_edge = read_taken & rx_read_enable_n_prev_q;
  wire [ADDR_W-1:0] cur_chan = sel_edge ? addr_s : chan_q;
  // an empty fifo gives an invalid word; the reader watches valid
  wire word_ok = fifo_avail;
  wire in_pkt = cfg_packet_mode;
  wire wide = cfg_level3;

  // ----------------------------------------------------------------
  // next word shaping
  // ----------------------------------------------------------------
  // channel report only in level 3 packet mode
  wire report = in_pkt & wide & fifo_chan_report & word_ok;
  wire [DATA_W-1:0] chan_word =
    {{(DATA_W-CHAN_W){1'b0}}, {(CHAN_W-ADDR_W){1'b0}}, cur_chan};
  // fifo word is stored msb-first, first bit lands on lane 31
  wire [DATA_W-1:0] raw_word = report ? chan_word : fifo_data;
  // upper lanes forced to zero in level 2
  wire [DATA_W-1:0] next_data = wide ? raw_word :
    {{(DATA_W-HALF_W){1'b0}}, raw_word[HALF_W-1:0]};
  // level 2 reduction sees only the low half since upper is zero
  wire even_par = ^next_data;
  wire next_par = even_par ^ cfg_odd_parity;
  wire last_ok = in_pkt & word_ok & ~report & fifo_last;
  // cell start marker
  wire next_soc = ~in_pkt & word_ok & fifo_first;
  wire next_sop = in_pkt & word_ok & ~report & fifo_first;
  // modulo only meaningful with end; level 2 uses bit 0 only
  wire [MOD_W-1:0] next_mod = ~last_ok ? MOD_RST :
    (wide ? fifo_mod : {1'b0, fifo_mod[0]});
  // error never without end
  wire next_err = last_ok & fifo_bad;
  wire next_val = in_pkt & word_ok & ~report;
  wire next_sx = report;

  // pop only a real data word; a report word stays in the fifo
  assign fifo_pop = read_taken & word_ok & ~report;
  assign fifo_channel = cur_chan;

  // ----------------------------------------------------------------
  // edge history and channel select
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rclk_prev_q <= 1'b0;
      rx_read_enable_n_prev_q <= 1'b1;
      chan_q <= ADDR_RST;
    end else if (clk_en) begin
      rclk_prev_q <= rclk_s;
      if (rclk_rise) begin
        rx_read_enable_n_prev_q <= rx_read_enable_n_s;
      end
      if (sel_edge) begin
        chan_q <= addr_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers: load on a taken read, else hold
  // ----------------------------------------------------------------
  // dropping enable at any point simply holds the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= DATA_RST;
      par_q <= 1'b0;
      soc_q <= 1'b0;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      mod_q <= MOD_RST;
      err_q <= 1'b0;
      val_q <= 1'b0;
      sx_q <= 1'b0;
    end else if (clk_en && read_taken) begin
      data_q <= next_data;
      par_q <= next_par;
      soc_q <= next_soc;
      sop_q <= next_sop;
      eop_q <= last_ok;
      mod_q <= next_mod;
      err_q <= next_err;
      val_q <= next_val;
      sx_q <= next_sx;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign rx_data_bus = data_q;
  assign rx_data_parity = par_q;
  assign rx_start_of_cell = soc_q;
  assign rx_start_of_packet = sop_q;
  assign rx_end_of_packet = eop_q;
  assign rx_word_modulo = mod_q;
  assign rx_packet_error = err_q;
  assign rx_data_valid = val_q;
  assign rx_transfer_start = sx_q;
endmodule : rxsp_port

// >>> hw/rxsp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of external levels
module rxsp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // two stages; the first feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : rxsp_sync
